// [ncr_command_register.sv]
// controller command register of the network controller
// this file holds the top module; it assumes the host register port, the transmitter,
// receiver and remote dma engine all run on clk_in and keep their own obligations
// a halt while not halted, or an error while running, leaves the controller draining until both busy inputs fall;
// reset_done_out is the only sign that the drain is over and should set the
// reset-complete flag of the event flag register
// the block has no view of the byte count registers: rdma_count_load_in stands in
// for a host write to them and rdma_count_zero_in for the engine's remaining count
`timescale 1ns/1ps
`default_nettype none

module ncr_command_register (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // host register port
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rdata_valid_out,
  // command register contents and page
  output logic [7:0] controller_command_out,
  output logic [1:0] page_select_out,
  output logic [3:0] page_onehot_out,
  // controller state
  output logic online_out,
  output logic reset_done_out,
  input wire logic error_reset_in,
  input wire logic rx_busy_in,
  // transmitter
  output logic tx_start_out,
  input wire logic tx_busy_in,
  input wire logic tx_done_in,
  // remote dma engine
  output logic [2:0] rdma_op_out,
  output logic rdma_start_out,
  output logic rdma_abort_out,
  output logic rdma_done_now_out,
  input wire logic rdma_done_in,
  input wire logic rdma_count_zero_in,
  input wire logic rdma_count_load_in,
  input wire logic rdma_req_in,
  // external port handshake
  output logic port_request_out,
  input wire logic port_read_ack_in,
  input wire logic port_write_ack_in
);

  ncr_pkg::ncr_state_s s_q;
  ncr_pkg::ncr_state_s s_d;

  ncr_pkg::ncr_cmd_s wcmd;
  logic cmd_wr;
  logic cmd_rd;
  logic [3:0] next_onehot;
  logic tx_idle;
  logic rdma_code_start;
  logic rdma_same_op;
  logic port_ack;

  assign wcmd = ncr_pkg::ncr_cmd_s'(reg_wdata_in);
  // the command register sits at the same address on every page
  assign cmd_wr = reg_wr_in && (reg_addr_in == ncr_pkg::CMD_OFFSET);
  // other addresses belong to other registers and are ignored here
  assign cmd_rd = reg_rd_in && (reg_addr_in == ncr_pkg::CMD_OFFSET);
  assign tx_idle = !tx_busy_in && !rx_busy_in;
  assign rdma_code_start = !wcmd.rdma[2] && (wcmd.rdma != ncr_pkg::NCR_RDMA_NONE);
  assign rdma_same_op = s_q.rdma_active && (wcmd.rdma == s_q.rdma_op);
  assign port_ack = port_read_ack_in || port_write_ack_in;

  // the decoder sees the next page so the one-hot copy moves with the page bits
  ncr_page_decode ncr_page_decode_i (
    .page_in(s_d.cmd.page),
    .onehot_out(next_onehot)
  );

  always_comb begin
    s_d = s_q;
    // one-cycle strobes fall back every cycle
    s_d.tx_start = 1'b0;
    s_d.rdma_start = 1'b0;
    s_d.rdma_abort = 1'b0;
    s_d.rdma_done_now = 1'b0;
    s_d.reset_done = 1'b0;
    s_d.rdata_valid = 1'b0;
    s_d.rdata = ncr_pkg::RDATA_IDLE;

    // ---- transmit request bit ----
    // done clears first; a new request in the same cycle is dropped because the old bit was still set
    if (tx_done_in) begin
      s_d.cmd.tx = 1'b0;
    end

    // ---- remote dma engine completion ----
    // natural completion leaves the command field as the host wrote it
    if (rdma_done_in) begin
      s_d.rdma_active = 1'b0;
    end

    // ---- port request follows the engine, held after an early abort ----
    if (port_ack) begin
      s_d.prq_hold = 1'b0;
    end

    // ---- byte count reload tracking ----
    // a load in the same cycle as a start still counts for that start
    if (rdma_count_load_in) begin
      s_d.reloaded = 1'b1;
    end

    // ---- operating state ----
    case (s_q.ctrl)
      ncr_pkg::NCR_RUNNING: begin
        s_d.online = 1'b1;
      end
      ncr_pkg::NCR_STOPPING: begin
        // packets in flight finish before the offline state is entered
        s_d.online = 1'b0;
        if (tx_idle) begin
          s_d.ctrl = ncr_pkg::NCR_HALTED;
          s_d.reset_done = 1'b1;
        end
      end
      ncr_pkg::NCR_HALTED: begin
        s_d.online = 1'b0;
      end
      default: begin
        s_d.ctrl = ncr_pkg::NCR_HALTED;
        s_d.online = 1'b0;
      end
    endcase

    // an internal error puts the controller into reset like a halt command
    // an error seen while halted or draining changes nothing
    if (error_reset_in && (s_q.ctrl == ncr_pkg::NCR_RUNNING)) begin
      s_d.cmd.halt = 1'b1;
      s_d.ctrl = ncr_pkg::NCR_STOPPING;
      s_d.online = 1'b0;
    end

    // ---- host write of the command byte ----
    if (cmd_wr) begin
      // page select is taken whatever runs
      s_d.cmd.page = wcmd.page;

      // halt and run
      // halt wins over run and transmit written in the same byte
      if (wcmd.halt) begin
        s_d.cmd.halt = 1'b1;
        // run stays set when the controller had been started
        s_d.cmd.run = s_q.cmd.run || wcmd.run;
        if (s_q.ctrl != ncr_pkg::NCR_HALTED) begin
          s_d.ctrl = ncr_pkg::NCR_STOPPING;
          s_d.online = 1'b0;
        end else begin
          // already offline: the reset completes at once
          s_d.reset_done = 1'b1;
        end
      end else if (wcmd.run) begin
        s_d.cmd.halt = 1'b0;
        s_d.cmd.run = 1'b1;
        // a run while still draining is taken only if the drain ends in that same cycle, else the controller stays in NCR_STOPPING
        // limitation: it does not restart later, the host must write run again
        if (s_d.ctrl == ncr_pkg::NCR_HALTED) begin
          s_d.ctrl = ncr_pkg::NCR_RUNNING;
          s_d.online = 1'b1;
        end else if (s_d.ctrl == ncr_pkg::NCR_STOPPING) begin
          s_d.ctrl = ncr_pkg::NCR_STOPPING;
        end
      end else begin
        s_d.cmd.run = 1'b0;
      end

      // transmit request: only a one has an effect
      if (wcmd.tx && !s_q.cmd.tx && (s_q.ctrl == ncr_pkg::NCR_RUNNING) && !wcmd.halt) begin
        s_d.cmd.tx = 1'b1;
        s_d.tx_start = 1'b1;
      end

      // remote dma command field
      if (wcmd.rdma[2]) begin
        // abort or complete, lower bits do not matter
        s_d.cmd.rdma = wcmd.rdma;
        if (s_q.rdma_active) begin
          s_d.rdma_abort = 1'b1;
          s_d.rdma_active = 1'b0;
          // start address is left where the dma stopped
          if (!rdma_count_zero_in) begin
            s_d.prq_hold = 1'b1;
          end
        end
      end else if (rdma_code_start) begin
        // a repeated code while the dma runs is the host keeping the bits
        // alongside a transmit request, so it must not restart the channel
        if (!rdma_same_op) begin
          s_d.cmd.rdma = wcmd.rdma;
          s_d.rdma_op = ncr_pkg::ncr_rdma_e'(wcmd.rdma);
          if (s_q.reloaded || rdma_count_load_in) begin
            s_d.rdma_start = 1'b1;
            s_d.rdma_active = 1'b1;
            s_d.reloaded = 1'b0;
          end else begin
            // count still spent from the last run: nothing to move
            s_d.rdma_done_now = 1'b1;
            s_d.rdma_active = 1'b0;
          end
        end
      end
      // code 000 is illegal and leaves the field untouched
    end

    // an early abort holds the request; a fresh start hands it back to the engine
    // while no dma is active the engine's request is ignored
    if (s_d.rdma_active) begin
      s_d.port_request = rdma_req_in;
    end else begin
      s_d.port_request = s_d.prq_hold;
    end

    // ---- host read of the command byte ----
    // read data is the byte before this cycle's changes take effect
    if (cmd_rd) begin
      s_d.rdata = s_q.cmd;
      s_d.rdata_valid = 1'b1;
    end

    s_d.page_onehot = next_onehot;
  end

  // each field is reset by name so the reset branch holds only constants
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q.cmd.page <= ncr_pkg::PAGE_RESET;
      s_q.cmd.rdma <= ncr_pkg::RDMA_RESET;
      s_q.cmd.tx <= ncr_pkg::TX_RESET;
      s_q.cmd.run <= ncr_pkg::RUN_RESET;
      s_q.cmd.halt <= ncr_pkg::HALT_RESET;
      s_q.ctrl <= ncr_pkg::NCR_HALTED;
      s_q.online <= 1'b0;
      s_q.rdma_active <= 1'b0;
      s_q.rdma_op <= ncr_pkg::NCR_RDMA_NONE;
      s_q.reloaded <= 1'b0;
      s_q.prq_hold <= 1'b0;
      s_q.port_request <= 1'b0;
      s_q.tx_start <= 1'b0;
      s_q.rdma_start <= 1'b0;
      s_q.rdma_abort <= 1'b0;
      s_q.rdma_done_now <= 1'b0;
      s_q.reset_done <= 1'b0;
      s_q.page_onehot <= ncr_pkg::ONEHOT_RESET;
      s_q.rdata <= ncr_pkg::RDATA_IDLE;
      s_q.rdata_valid <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // every output is a field of the registered state
  // page_select_out repeats bits 7:6 for the address decode of the other pages
  assign reg_rdata_out = s_q.rdata;
  assign reg_rdata_valid_out = s_q.rdata_valid;
  assign controller_command_out = s_q.cmd;
  assign page_select_out = s_q.cmd.page;
  assign page_onehot_out = s_q.page_onehot;
  assign online_out = s_q.online;
  assign reset_done_out = s_q.reset_done;
  assign tx_start_out = s_q.tx_start;
  assign rdma_op_out = s_q.rdma_op;
  assign rdma_start_out = s_q.rdma_start;
  assign rdma_abort_out = s_q.rdma_abort;
  assign rdma_done_now_out = s_q.rdma_done_now;
  assign port_request_out = s_q.port_request;

endmodule

`default_nettype wire

// [ncr_command_register_props.sv]
// checker for the command register block, bound to its top module
// assumes the top module ports as declared by the design
`timescale 1ns/1ps
`default_nettype none
module ncr_command_register_props (
  // clock, reset and host port
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rdata_valid_out,
  // command state
  input wire logic [7:0] controller_command_out,
  input wire logic [1:0] page_select_out,
  input wire logic [3:0] page_onehot_out,
  input wire logic online_out,
  input wire logic reset_done_out,
  input wire logic rx_busy_in,
  // transmitter and dma
  input wire logic tx_busy_in,
  input wire logic tx_done_in,
  input wire logic tx_start_out,
  input wire logic rdma_abort_out,
  input wire logic rdma_count_zero_in,
  input wire logic rdma_req_in,
  input wire logic port_request_out,
  input wire logic port_read_ack_in,
  input wire logic port_write_ack_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire cmd_wr = reg_wr_in && reg_addr_in == 4'h0;
  sequence s_halt_wr;
    cmd_wr && reg_wdata_in[0];
  endsequence
  sequence s_abort_early;
    rdma_abort_out && !$past(rdma_count_zero_in);
  endsequence
  AST_RESET_VAL: assert property ($past(rst_in) |-> controller_command_out == 8'h21 && !online_out)
    else $error("command byte wrong after reset");
  AST_READ_BACK: assert property (reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_valid_out
    && reg_rdata_out == $past(controller_command_out)) else $error("read data wrong");
  AST_HALT_OFF: assert property (s_halt_wr |=> !online_out && controller_command_out[0])
    else $error("halt write did not stop");
  AST_HALT_RUN: assert property (s_halt_wr ##0 online_out |=> controller_command_out[1:0] == 2'b11)
    else $error("halt while running lost run bit");
  AST_DONE_DRAIN: assert property (reset_done_out |-> !$past(tx_busy_in) && !$past(rx_busy_in) ##1 !reset_done_out)
    else $error("reset done while busy");
  AST_TX_KEEP: assert property (cmd_wr && !reg_wdata_in[2] && controller_command_out[2] && !tx_done_in
    |=> controller_command_out[2]) else $error("zero write cleared tx bit");
  AST_TX_CLR: assert property (tx_done_in && !cmd_wr |=> !controller_command_out[2])
    else $error("tx bit not cleared");
  AST_TX_PULSE: assert property (tx_start_out |-> controller_command_out[2] ##1 !tx_start_out)
    else $error("tx start pulse wrong");
  AST_PAGE_MAP: assert property (page_onehot_out == (4'h1 << page_select_out)
    && page_select_out == controller_command_out[7:6]) else $error("page decode wrong");
  AST_ABORT_HOLD: assert property (s_abort_early |-> port_request_out && controller_command_out[5])
    else $error("port request not held");
  AST_ACK_DROP: assert property ((port_read_ack_in || port_write_ack_in) && !rdma_req_in
    && !(cmd_wr && reg_wdata_in[5]) |=> !port_request_out) else $error("ack did not drop request");
endmodule
bind ncr_command_register ncr_command_register_props ncr_command_register_props_i (.clk_in, .rst_in,
  .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rdata_valid_out,
  .controller_command_out, .page_select_out, .page_onehot_out, .online_out, .reset_done_out,
  .rx_busy_in, .tx_busy_in, .tx_done_in, .tx_start_out, .rdma_abort_out, .rdma_count_zero_in,
  .rdma_req_in, .port_request_out, .port_read_ack_in, .port_write_ack_in);
`default_nettype wire

// [ncr_command_register_tb.sv]
// testbench for the command register block
// assumes the host model and the bound checker; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module ncr_command_register_tb;
  logic clk_in, rst_in, reg_wr_in, reg_rd_in, reg_rdata_valid_out, online_out, reset_done_out;
  logic [3:0] reg_addr_in, page_onehot_out;
  logic [7:0] reg_wdata_in, reg_rdata_out, controller_command_out;
  logic [1:0] page_select_out;
  logic [2:0] rdma_op_out;
  logic rx_busy_in, tx_busy_in, tx_done_in, tx_start_out, rdma_start_out, rdma_abort_out;
  logic rdma_done_now_out, rdma_count_zero_in, rdma_count_load_in, port_request_out, port_read_ack_in;
  logic port_write_ack_in, error_reset_in;
  int errors, checks_done, cycles;
  ncr_command_register ncr_command_register_i (.clk_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
    .reg_wdata_in, .reg_rdata_out, .reg_rdata_valid_out, .controller_command_out, .page_select_out,
    .page_onehot_out, .online_out, .reset_done_out, .error_reset_in, .rx_busy_in, .tx_start_out,
    .tx_busy_in, .tx_done_in, .rdma_op_out, .rdma_start_out, .rdma_abort_out, .rdma_done_now_out,
    .rdma_done_in(1'b0), .rdma_count_zero_in, .rdma_count_load_in, .rdma_req_in(1'b0), .port_request_out,
    .port_read_ack_in, .port_write_ack_in);
  ncr_host_model ncr_host_model_i (.clk_in, .reg_addr_out(reg_addr_in), .reg_wr_out(reg_wr_in),
    .reg_rd_out(reg_rd_in), .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out),
    .reg_rdata_valid_in(reg_rdata_valid_out));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic strobe_load;
    @(negedge clk_in);
    rdma_count_load_in = 1'b1;
    @(negedge clk_in);
    rdma_count_load_in = 1'b0;
  endtask
  task automatic t_reset;
    logic [7:0] d;
    logic v;
    chk(controller_command_out, 8'h21);
    ncr_host_model_i.rd(d, v);
    chk(d, 8'h21);
    chk({7'h0, v}, 8'h01);
    ncr_host_model_i.wr(4'h5, 8'hff);
    chk(controller_command_out, 8'h21);
    ncr_host_model_i.wr(4'h0, 8'h22);
    chk(controller_command_out, 8'h22);
    chk({7'h0, online_out}, 8'h01);
  endtask
  task automatic t_tx;
    ncr_host_model_i.wr(4'h0, 8'h26);
    chk({7'h0, tx_start_out}, 8'h01);
    ncr_host_model_i.wr(4'h0, 8'h22);
    chk(controller_command_out, 8'h26);
    tx_done_in = 1'b1;
    @(negedge clk_in);
    tx_done_in = 1'b0;
    chk(controller_command_out, 8'h22);
  endtask
  task automatic t_rdma;
    strobe_load();
    ncr_host_model_i.wr(4'h0, 8'h0a);
    chk({4'h0, rdma_start_out, rdma_op_out}, 8'h09);
    ncr_host_model_i.wr(4'h0, 8'h22);
    chk({6'h0, rdma_abort_out, port_request_out}, 8'h03);
    port_read_ack_in = 1'b1;
    @(negedge clk_in);
    port_read_ack_in = 1'b0;
    chk({7'h0, port_request_out}, 8'h00);
    ncr_host_model_i.wr(4'h0, 8'h12);
    chk({4'h0, rdma_done_now_out, rdma_op_out}, 8'h0a);
    strobe_load();
    ncr_host_model_i.wr(4'h0, 8'h1a);
    chk({4'h0, rdma_start_out, rdma_op_out}, 8'h0b);
    rdma_count_zero_in = 1'b1;
    ncr_host_model_i.wr(4'h0, 8'h22);
    chk({6'h0, rdma_abort_out, port_request_out}, 8'h02);
    ncr_host_model_i.wr(4'h0, 8'h02);
    chk(controller_command_out, 8'h22);
  endtask
  task automatic t_ack;
    strobe_load();
    ncr_host_model_i.wr(4'h0, 8'h12);
    chk({4'h0, rdma_start_out, rdma_op_out}, 8'h0a);
    ncr_host_model_i.wr(4'h0, 8'h16);
    chk({6'h0, tx_start_out, rdma_start_out}, 8'h02);
    tx_done_in = 1'b1;
    @(negedge clk_in);
    tx_done_in = 1'b0;
    chk(controller_command_out, 8'h12);
    rdma_count_zero_in = 1'b0;
    ncr_host_model_i.wr(4'h0, 8'h22);
    chk({6'h0, rdma_abort_out, port_request_out}, 8'h03);
    port_write_ack_in = 1'b1;
    @(negedge clk_in);
    port_write_ack_in = 1'b0;
    chk({7'h0, port_request_out}, 8'h00);
  endtask
  task automatic t_error;
    error_reset_in = 1'b1;
    @(negedge clk_in);
    error_reset_in = 1'b0;
    chk(controller_command_out, 8'h23);
    chk({7'h0, online_out}, 8'h00);
    @(negedge clk_in);
    chk({7'h0, reset_done_out}, 8'h01);
    ncr_host_model_i.wr(4'h0, 8'h22);
    chk({7'h0, online_out}, 8'h01);
  endtask
  task automatic t_page;
    for (int p = 0; p < 4; p++) begin
      ncr_host_model_i.wr(4'h0, {p[1:0], 6'h22});
      chk({4'h0, page_onehot_out}, 8'h01 << p);
      chk({6'h0, page_select_out}, p[7:0]);
    end
  endtask
  task automatic t_halt;
    tx_busy_in = 1'b1;
    ncr_host_model_i.wr(4'h0, 8'h23);
    chk({5'h0, online_out, controller_command_out[1:0]}, 8'h03);
    repeat (2) @(negedge clk_in);
    chk({7'h0, reset_done_out}, 8'h00);
    tx_busy_in = 1'b0;
    for (int i = 0; i < 4 && reset_done_out !== 1'b1; i++) @(negedge clk_in);
    chk({7'h0, reset_done_out}, 8'h01);
    ncr_host_model_i.wr(4'h0, 8'h22);
    chk({7'h0, online_out}, 8'h01);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    {rst_in, rx_busy_in, tx_busy_in, tx_done_in} = 4'hf;
    {rx_busy_in, tx_busy_in, tx_done_in, rdma_count_zero_in, rdma_count_load_in, port_read_ack_in} = 6'h0;
    {error_reset_in, port_write_ack_in} = 2'h0;
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    t_reset();
    t_tx();
    t_rdma();
    t_ack();
    t_page();
    t_halt();
    t_error();
    test_done();
  end
endmodule
`default_nettype wire

// [ncr_host_model.sv]
// host model: drives the register port of the command register block
// assumes callers run aligned to the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module ncr_host_model (
  // clock
  input wire logic clk_in,
  // register port
  output logic [3:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_rdata_valid_in
);
  initial begin
    reg_addr_out = 4'h0;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // idle data is inverted so a stale byte never passes for a write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge clk_in);
    reg_wr_out = 1'b0;
    reg_wdata_out = ~d;
  endtask
  task automatic rd(output logic [7:0] d, output logic v);
    @(negedge clk_in);
    reg_addr_out = 4'h0;
    reg_rd_out = 1'b1;
    @(negedge clk_in);
    reg_rd_out = 1'b0;
    d = reg_rdata_in;
    v = reg_rdata_valid_in;
  endtask
endmodule
`default_nettype wire

// [ncr_page_decode.sv]
// page select decoder for the controller command register block
// turns the two page bits into a one-hot page strobe, bit 3 marks the reserved page
// assumes the page bits are the next value of the command register page field
`timescale 1ns/1ps
`default_nettype none

module ncr_page_decode (
  // page select field
  input wire logic [1:0] page_in,
  // one-hot page
  output logic [3:0] onehot_out
);

  always_comb begin
    case (page_in)
      ncr_pkg::PAGE0: onehot_out = 4'h1;
      ncr_pkg::PAGE1: onehot_out = 4'h2;
      ncr_pkg::PAGE2: onehot_out = 4'h4;
      ncr_pkg::PAGE_RSVD: onehot_out = 4'h8;
      default: onehot_out = 4'h8;
    endcase
  end

endmodule

`default_nettype wire

// [ncr_pkg.sv]
// package for the controller command register block
// holds offsets, field positions, reset values, commands and the state layout
// assumes a host register port with four address lines and 8-bit data
package ncr_pkg;

  // register map (command register answers on every page)
  localparam logic [3:0] CMD_OFFSET = 4'h0;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // field positions inside the command byte
  localparam int HALT_BIT = 0;
  localparam int RUN_BIT = 1;
  localparam int TX_BIT = 2;
  localparam int RDMA_LSB = 3;
  localparam int RDMA_MSB = 5;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_MSB = 7;

  // value after power-up: halted, not running, dma field idle, page 0
  localparam logic [1:0] PAGE_RESET = 2'h0;
  localparam logic [2:0] RDMA_RESET = 3'h4;
  localparam logic TX_RESET = 1'b0;
  localparam logic RUN_RESET = 1'b0;
  localparam logic HALT_RESET = 1'b1;
  localparam logic [7:0] CMD_RESET = 8'h21;

  // read data on a read of an address this block does not own
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // page select codes
  localparam logic [1:0] PAGE0 = 2'h0;
  localparam logic [1:0] PAGE1 = 2'h1;
  localparam logic [1:0] PAGE2 = 2'h2;
  localparam logic [1:0] PAGE_RSVD = 2'h3;
  localparam logic [3:0] ONEHOT_RESET = 4'h1;

  // remote dma command codes
  typedef enum logic [2:0] {
    NCR_RDMA_NONE = 3'b000,
    NCR_RDMA_READ = 3'b001,
    NCR_RDMA_WRITE = 3'b010,
    NCR_RDMA_SEND = 3'b011,
    NCR_RDMA_ABORT = 3'b100
  } ncr_rdma_e;

  // controller operating state
  typedef enum logic [1:0] {
    NCR_HALTED = 2'b00,
    NCR_STOPPING = 2'b01,
    NCR_RUNNING = 2'b10
  } ncr_ctrl_e;

  // command byte as seen by the host, msb first
  typedef struct packed {
    logic [1:0] page;
    logic [2:0] rdma;
    logic tx;
    logic run;
    logic halt;
  } ncr_cmd_s;

  // whole state of the block
  typedef struct packed {
    ncr_cmd_s cmd;
    ncr_ctrl_e ctrl;
    logic online;
    logic rdma_active;
    ncr_rdma_e rdma_op;
    logic reloaded;
    logic prq_hold;
    logic port_request;
    logic tx_start;
    logic rdma_start;
    logic rdma_abort;
    logic rdma_done_now;
    logic reset_done;
    logic [3:0] page_onehot;
    logic [7:0] rdata;
    logic rdata_valid;
  } ncr_state_s;

endpackage
